//--- design/bbx_pkg.sv
// package: encodings, field positions and reset values for branch/bit-set execution
package bbx_pkg;
  localparam int unsigned OPC_W          = 16;
  localparam int unsigned PC_W           = 21;
  localparam int unsigned DADDR_W        = 12;
  localparam logic [7:0]  OPC_JNN        = 8'hE7;
  localparam logic [7:0]  OPC_JNOV       = 8'hE5;
  localparam logic [7:0]  OPC_JNZ        = 8'hE1;
  localparam logic [4:0]  OPC_JREL       = 5'h1A;
  localparam logic [3:0]  OPC_SETBIT     = 4'h8;
  localparam int unsigned HI_BYTE_LSB    = 8;
  localparam int unsigned JREL_LSB       = 11;
  localparam int unsigned SETBIT_LSB     = 12;
  localparam int unsigned BIT_SEL_LSB    = 9;
  localparam int unsigned BANK_SEL_POS   = 8;
  localparam logic [7:0]  IDX_LIMIT      = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [PC_W-1:0] PC_RST     = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP    = 21'h000002;
  localparam logic [7:0]  DATA_RST       = 8'h00;
endpackage

//--- design/bbx_reg_file.sv
// small data memory: registered read, write on i_wr_en
`timescale 1ns/1ps
module bbx_reg_file #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 8
) (
  // clock
  input  wire logic          i_sys_clk,
  // read port
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [DW-1:0] o_rd_data,
  // write port
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [DW-1:0] i_wr_data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

//--- design/bbx_exec.sv
// branch and bit-set execution core with four-phase instruction cycle
// Overview of operation
// - jump_if_negative_clear 0xE7: jump when N is 0
// - jump_if_overflow_clear 0xE5: jump when OV is 0
// - jump_if_zero_clear 0xE1: jump when Z is 0
// - target is PC plus 2 plus 2n
// - conditional: one cycle, two when taken
// - phases decode, literal, process, write PC
// - relative_jump_always 11-bit offset, always two cycles
// - set_register_bit sets bit b, one cycle
// - a=0 access bank, a=1 bank_selector bank
// - a=0, extended, f<=95 uses indexed offset
`timescale 1ns/1ps
module bbx_exec #(
  parameter int unsigned AW = bbx_pkg::DADDR_W
) (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  // instruction fetch
  input  wire logic                     i_instr_valid,
  input  wire logic [bbx_pkg::OPC_W-1:0] i_instr,
  // status flags and configuration
  input  wire logic                     i_flag_n,
  input  wire logic                     i_flag_ov,
  input  wire logic                     i_flag_z,
  input  wire logic                     i_ext_set_en,
  input  wire logic [3:0]               i_bank_selector,
  input  wire logic [AW-1:0]            i_index_base,
  // program counter and status
  output logic [bbx_pkg::PC_W-1:0]      o_pc,
  output logic                          o_pc_load,
  output logic [1:0]                    o_phase,
  output logic                          o_busy,
  output logic                          o_flags_write,
  // data memory observation
  output logic                          o_mem_wr,
  output logic [AW-1:0]                 o_mem_addr,
  output logic [7:0]                    o_mem_wdata
);
  import bbx_pkg::*;

  typedef enum logic [1:0] {
    BBX_Q1 = 2'b00,
    BBX_Q2 = 2'b01,
    BBX_Q3 = 2'b11,
    BBX_Q4 = 2'b10
  } bbx_phase_t;

  typedef enum logic [2:0] {
    BBX_OP_NONE,
    BBX_OP_JNN,
    BBX_OP_JNOV,
    BBX_OP_JNZ,
    BBX_OP_JREL,
    BBX_OP_SETBIT
  } bbx_op_t;

  bbx_phase_t         phase_ff;
  bbx_phase_t         nxt_phase;
  bbx_op_t            op_ff;
  logic [OPC_W-1:0]   ir_ff;
  logic               stall_ff;
  logic               nop_cycle_ff;
  logic               taken_ff;
  logic [PC_W-1:0]    pc_ff;
  logic [PC_W-1:0]    target_ff;
  logic [AW-1:0]      ea_ff;
  logic [7:0]         wdata_ff;
  logic               wr_ff;
  logic               pc_load_ff;
  logic [7:0]         rd_data;
  logic [AW-1:0]      ea_comb;

  function automatic bbx_op_t decode(input logic [OPC_W-1:0] w);
    logic [7:0] hi;
    hi = w[OPC_W-1:HI_BYTE_LSB];
    if (hi == OPC_JNN) return BBX_OP_JNN;
    if (hi == OPC_JNOV) return BBX_OP_JNOV;
    if (hi == OPC_JNZ) return BBX_OP_JNZ;
    if (w[OPC_W-1:JREL_LSB] == OPC_JREL) return BBX_OP_JREL;
    if (w[OPC_W-1:SETBIT_LSB] == OPC_SETBIT) return BBX_OP_SETBIT;
    return BBX_OP_NONE;
  endfunction

  // pc + 2 + 2n with sign-extended offset
  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input logic [PC_W-1:0] n_sx);
    return PC_W'(pc + PC_STEP + {n_sx[PC_W-2:0], 1'b0});
  endfunction

  assign nxt_phase = (phase_ff == BBX_Q1) ? BBX_Q2 :
                     (phase_ff == BBX_Q2) ? BBX_Q3 :
                     (phase_ff == BBX_Q3) ? BBX_Q4 : BBX_Q1;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      phase_ff <= BBX_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // decode at Q1 unless the forced no-op cycle is running
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      op_ff        <= BBX_OP_NONE;
      ir_ff        <= '0;
      nop_cycle_ff <= 1'b0;
    end else if (phase_ff == BBX_Q1) begin
      nop_cycle_ff <= stall_ff;
      if (!stall_ff && i_instr_valid) begin
        op_ff <= decode(i_instr);
        ir_ff <= i_instr;
      end else begin
        op_ff <= BBX_OP_NONE;
        ir_ff <= '0;
      end
    end
  end

  // branch condition and target computed in Q2
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      taken_ff  <= 1'b0;
      target_ff <= PC_RST;
    end else if (phase_ff == BBX_Q2) begin
      unique case (op_ff)
        BBX_OP_JNN:  taken_ff <= !i_flag_n;
        BBX_OP_JNOV: taken_ff <= !i_flag_ov;
        BBX_OP_JNZ:  taken_ff <= !i_flag_z;
        BBX_OP_JREL: taken_ff <= 1'b1;
        default:     taken_ff <= 1'b0;
      endcase
      if (op_ff == BBX_OP_JREL) begin
        target_ff <= rel_target(pc_ff, PC_W'(signed'(ir_ff[JREL_LSB-1:0])));
      end else begin
        target_ff <= rel_target(pc_ff, PC_W'(signed'(ir_ff[HI_BYTE_LSB-1:0])));
      end
    end
  end

  // pc: written in Q4 when taken, held in the no-op cycle or with no instruction, else advanced by one word
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pc_ff      <= PC_RST;
      pc_load_ff <= 1'b0;
      stall_ff   <= 1'b0;
    end else begin
      pc_load_ff <= 1'b0;
      if (phase_ff == BBX_Q4) begin
        if (taken_ff && !nop_cycle_ff) begin
          pc_ff      <= target_ff;
          pc_load_ff <= 1'b1;
          stall_ff   <= 1'b1;
        end else begin
          stall_ff <= 1'b0;
          if (!nop_cycle_ff && op_ff != BBX_OP_NONE) begin
            pc_ff <= PC_W'(pc_ff + PC_STEP);
          end else if (!nop_cycle_ff && i_instr_valid) begin
            pc_ff <= PC_W'(pc_ff + PC_STEP);
          end
        end
      end
    end
  end

  // bit-set effective address: access bank, bank_selector, or indexed
  always_comb begin
    logic [7:0] f;
    f = ir_ff[7:0];
    if (ir_ff[BANK_SEL_POS]) begin
      ea_comb = AW'({i_bank_selector, f});
    end else if (i_ext_set_en && f <= IDX_LIMIT) begin
      ea_comb = AW'(i_index_base + AW'(f));
    end else if (f < ACCESS_SPLIT) begin
      ea_comb = AW'({4'h0, f});
    end else begin
      ea_comb = AW'({ACCESS_HI_BANK, f});
    end
  end

  // read Q2, modify Q3, write Q4
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ea_ff    <= '0;
      wdata_ff <= DATA_RST;
      wr_ff    <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      unique case (phase_ff)
        BBX_Q1: ;
        BBX_Q2: ea_ff <= ea_comb;
        BBX_Q3: wdata_ff <= rd_data | (8'h01 << ir_ff[BIT_SEL_LSB +: 3]);
        BBX_Q4: wr_ff <= (op_ff == BBX_OP_SETBIT);
      endcase
    end
  end

  bbx_reg_file #(
    .AW (AW),
    .DW (8)
  ) u_reg_file (
    .i_sys_clk (i_sys_clk),
    .i_rd_addr (ea_comb),
    .o_rd_data (rd_data),
    .i_wr_en   (wr_ff),
    .i_wr_addr (ea_ff),
    .i_wr_data (wdata_ff)
  );

  assign o_pc          = pc_ff;
  assign o_pc_load     = pc_load_ff;
  assign o_phase       = phase_ff;
  assign o_busy        = nop_cycle_ff;
  assign o_flags_write = 1'b0;
  assign o_mem_wr      = wr_ff;
  assign o_mem_addr    = ea_ff;
  assign o_mem_wdata   = wdata_ff;
endmodule

//--- sim/bbx_exec_properties.sv
// port-level assertions for bbx_exec
`timescale 1ns/1ps
module bbx_exec_properties
  import bbx_pkg::*;
(
  // clock, reset, fetch and flags
  input wire logic             i_sys_clk,
  input wire logic             i_rst_n,
  input wire logic             i_instr_valid,
  input wire logic [OPC_W-1:0] i_instr,
  input wire logic             i_flag_n,
  input wire logic             i_flag_ov,
  input wire logic             i_flag_z,
  // observed outputs
  input wire logic [PC_W-1:0]  o_pc,
  input wire logic             o_pc_load,
  input wire logic [1:0]       o_phase,
  input wire logic             o_busy,
  input wire logic             o_flags_write,
  input wire logic             o_mem_wr,
  input wire logic [7:0]       o_mem_wdata
);
  logic            took_ff;
  logic [7:0]      hi_ff;
  logic [PC_W-1:0] seq_ff, tgt_ff;
  // a pending stall shows as o_pc_load at the refused Q1 edge
  wire take = i_rst_n && o_phase == 2'b00 && !o_pc_load && i_instr_valid;
  wire cnd = hi_ff inside {OPC_JNN, OPC_JNOV, OPC_JNZ};
  wire go = hi_ff == OPC_JNN ? !i_flag_n : hi_ff == OPC_JNOV ? !i_flag_ov : !i_flag_z;
  always_ff @(posedge i_sys_clk) took_ff <= take;
  // expected targets captured at instruction take
  always_ff @(posedge i_sys_clk) begin
    if (take) begin
      hi_ff <= i_instr[15:8];
      seq_ff <= o_pc + PC_STEP;
      tgt_ff <= o_pc + PC_STEP + (i_instr[13] ? {{12{i_instr[7]}}, i_instr[7:0], 1'b0}
                                              : {{9{i_instr[10]}}, i_instr[10:0], 1'b0});
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_phase_order: assert property (o_phase == 2'b01 |=> o_phase == 2'b11 ##1 o_phase == 2'b10 ##1 o_phase == 2'b00)
    else $error("phase order broken");
  a_flags_kept: assert property (!o_flags_write)
    else $error("status flags written");
  a_cond_taken: assert property (took_ff && cnd && go |-> ##3 o_pc_load && o_pc == tgt_ff ##1 o_busy)
    else $error("taken branch target wrong");
  a_cond_skip: assert property (took_ff && cnd && !go |-> ##3 !o_pc_load && o_pc == seq_ff ##1 !o_busy)
    else $error("untaken branch wrong");
  a_jump_always: assert property (took_ff && hi_ff[7:3] == OPC_JREL |-> ##3 o_pc_load && o_pc == tgt_ff ##1 o_busy)
    else $error("relative jump wrong");
  a_nop_span: assert property ($rose(o_busy) |-> o_busy[*4] ##1 !o_busy)
    else $error("no-op cycle length wrong");
  a_setbit_write: assert property (took_ff && hi_ff[7:4] == OPC_SETBIT |-> ##3 o_mem_wr && o_mem_wdata[hi_ff[3:1]])
    else $error("bit set write missing");
  a_write_phase: assert property (o_mem_wr |-> $past(o_phase) == 2'b10 && !o_busy)
    else $error("write-back out of phase");
endmodule

//--- sim/bbx_exec_test.sv
// self-checking bench for bbx_exec
`timescale 1ns/1ps
module bbx_exec_test;
  import bbx_pkg::*;
  logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic        i_flag_n = 1'b0, i_flag_ov = 1'b0, i_flag_z = 1'b0, i_ext_set_en = 1'b0;
  logic [3:0]  i_bank_selector = 4'h0;
  logic [11:0] i_index_base = 12'h000, o_mem_addr;
  logic [20:0] o_pc, pc_m = 21'h000000;
  logic        o_pc_load, o_busy, o_flags_write, o_mem_wr, bz_ff;
  logic        tk_ff = 1'b0, bz_due = 1'b0;
  logic [1:0]  o_phase, ph_ff;
  logic [7:0]  o_mem_wdata;
  logic [16:0] cfg = 17'h00000;
  logic [21:0] pcq[$];
  logic [19:0] mq[$];
  bit   [7:0]  mm[4096];
  int          err_count = 0, samples_checked = 0;
  bbx_exec dut (
    .i_sys_clk       (i_sys_clk),
    .i_rst_n         (i_rst_n),
    .i_instr_valid   (i_instr_valid),
    .i_instr         (i_instr),
    .i_flag_n        (i_flag_n),
    .i_flag_ov       (i_flag_ov),
    .i_flag_z        (i_flag_z),
    .i_ext_set_en    (i_ext_set_en),
    .i_bank_selector (i_bank_selector),
    .i_index_base    (i_index_base),
    .o_pc            (o_pc),
    .o_pc_load       (o_pc_load),
    .o_phase         (o_phase),
    .o_busy          (o_busy),
    .o_flags_write   (o_flags_write),
    .o_mem_wr        (o_mem_wr),
    .o_mem_addr      (o_mem_addr),
    .o_mem_wdata     (o_mem_wdata)
  );
  always #2 i_sys_clk = ~i_sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // drive one instruction at its Q1 and note the expected outcome
  task automatic issue(input logic [15:0] ins, input logic [2:0] fl);
    logic        tk;
    logic [7:0]  f;
    logic [11:0] ad;
    // skip the Q1 edge refused by a pending stall
    @(negedge i_sys_clk iff (o_phase === 2'b00 && o_pc_load === 1'b0));
    {i_instr, i_instr_valid, i_flag_n, i_flag_ov, i_flag_z} = {ins, 1'b1, fl};
    {i_ext_set_en, i_bank_selector, i_index_base} = cfg;
    f = ins[7:0];
    tk = ins[15:11] == OPC_JREL || (ins[15:8] == OPC_JNN && !fl[2])
      || (ins[15:8] == OPC_JNOV && !fl[1]) || (ins[15:8] == OPC_JNZ && !fl[0]);
    pc_m += PC_STEP;
    if (ins[15:11] == OPC_JREL) pc_m += {{9{ins[10]}}, ins[10:0], 1'b0};
    else if (tk) pc_m += {{12{ins[7]}}, f, 1'b0};
    pcq.push_back({tk, pc_m});
    if (ins[15:12] == OPC_SETBIT) begin
      ad = ins[8] ? {cfg[15:12], f} : cfg[16] && f <= 8'h5F ? cfg[11:0] + f : {f < 8'h60 ? 4'h0 : 4'hF, f};
      mm[ad] |= 8'h01 << ins[11:9];
      mq.push_back({ad, mm[ad]});
    end
  endtask
  initial begin
    logic [10:0] off;
    logic [2:0]  m, fl;
    void'($urandom(27074));
    repeat (6) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    for (int j = 0; j < 24; j++) begin
      off = j % 6 == 0 ? 11'h3FF : j % 6 == 1 ? 11'h400 : j % 6 == 2 ? 11'h07F : j % 6 == 3 ? 11'h080 : 11'($urandom);
      cfg = 17'($urandom);
      m = j < 12 ? 3'h4 : j < 18 ? 3'h2 : 3'h1;
      fl = j % 6 == 5 ? m : j % 6 == 4 ? ~m : 3'($urandom);
      if (j < 6) issue({OPC_JREL, off}, 3'($urandom));
      else issue({j < 12 ? OPC_JNN : j < 18 ? OPC_JNOV : OPC_JNZ, off[7:0]}, fl);
    end
    for (int j = 0; j < 26; j++) begin
      cfg = j > 23 ? 17'h13100 : 17'($urandom);
      issue(j == 24 ? 16'h825F : j == 25 ? 16'h8260 : {OPC_SETBIT, 12'($urandom)}, 3'($urandom));
    end
    cfg = 17'h00000;
    for (int j = 0; j < 8; j++) issue({OPC_SETBIT, 3'(j), 9'h020}, 3'h0);
    @(negedge i_sys_clk);
    i_instr_valid = 1'b0;
    for (int t = 0; t < 20 && pcq.size() + mq.size() > 0; t++) @(negedge i_sys_clk);
    repeat (2) @(negedge i_sys_clk);
    check(pcq.size() + mq.size(), 0);
    tally_and_finish();
  end
  // watcher: pops the oldest note when a result shows
  initial begin
    logic [21:0] e;
    logic [19:0] n;
    forever begin
      @(posedge i_sys_clk);
      #1;
      // no-op cycle flag rises one edge after the pc write
      if (bz_due) begin
        bz_due = 1'b0;
        check(o_busy, tk_ff);
      end
      if (o_mem_wr === 1'b1) begin
        n = mq.pop_front();
        check(o_mem_addr, n[19:8]);
        check(o_mem_wdata & n[7:0], n[7:0]);
      end
      if (o_phase === 2'b00 && ph_ff === 2'b10 && bz_ff === 1'b0 && pcq.size() > 0) begin
        e = pcq.pop_front();
        check({o_flags_write, o_pc_load, o_pc}, {1'b0, e});
        tk_ff  = e[21];
        bz_due = 1'b1;
      end
      ph_ff = o_phase;
      bz_ff = o_busy;
    end
  end
  initial begin
    #10000;
    err_count++;
    tally_and_finish();
  end
endmodule
bind bbx_exec bbx_exec_properties u_props (
  .i_sys_clk     (i_sys_clk),
  .i_rst_n       (i_rst_n),
  .i_instr_valid (i_instr_valid),
  .i_instr       (i_instr),
  .i_flag_n      (i_flag_n),
  .i_flag_ov     (i_flag_ov),
  .i_flag_z      (i_flag_z),
  .o_pc          (o_pc),
  .o_pc_load     (o_pc_load),
  .o_phase       (o_phase),
  .o_busy        (o_busy),
  .o_flags_write (o_flags_write),
  .o_mem_wr      (o_mem_wr),
  .o_mem_wdata   (o_mem_wdata)
);
